// ### shared/brake_pkg.sv
// Package: register map, field layouts, reset values and timing for brake/contactor control
package brake_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] SERVO_FUNC5_ADDR = 8'h00;
    localparam logic [7:0] SPINDLE_FUNC7_ADDR = 8'h04;
    localparam logic [7:0] REGEN_TYPE_ADDR = 8'h08;
    localparam logic [7:0] CONTROL_ADDR = 8'h0c;
    localparam logic [7:0] STATUS_ADDR = 8'h10;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int OUT3_SEL_LSB = 10;
    localparam int ESTOP_EN_LSB = 4;
    localparam int CTRL_SPINDLE_BIT = 0;
    localparam int CTRL_CONTACTOR_BIT = 1;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [1:0] OUT3_DISABLED = 2'h0;
    localparam logic [1:0] OUT3_CONTACTOR = 2'h2;
    localparam logic [3:0] ESTOP_DISABLED = 4'h0;
    localparam logic [3:0] ESTOP_ENABLED = 4'h4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] FUNC_WORD_RST = 16'h0000;
    localparam logic [1:0] CONTROL_RST = 2'h0;

    // ------------------------------------------------------------
    // Timing: delay from torque on to brake release
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int RELEASE_DELAY_NS = 100;
    localparam int RELEASE_DELAY_CYC = (RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_HELD = 2'b00,
        ST_POWERING = 2'b01,
        ST_RELEASED = 2'b10
    } brake_state_t;

endpackage : brake_pkg

// ### logic/brake_contactor_ctrl.sv
// Brake relay and contactor output sequencing with APB register access
// Register map, one aligned word each, upper half reads zero:
//   0x00 servo function word, output-three select in bits 11:10
//   0x04 spindle function word, same select field
//   0x08 regenerative resistor type word, stop input enable in bits 7:4
//   0x0c control: bit 0 spindle axis, bit 1 contactor request
//   0x10 status, read only: power, brake, contactor, drop prevention,
//        stop active, sequencer state
// Unmapped offsets read zero and ignore writes.
//
// The brake output is high while the brake is engaged, so a reset leaves
// the brake holding the axis; a lost clock keeps the last brake output.
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps

module brake_contactor_ctrl #(
    parameter int RELEASE_DELAY = brake_pkg::RELEASE_DELAY_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Drive core status and commands
    input wire logic servo_on_cmd,
    input wire logic nc_estop,
    input wire logic torque_on,
    // External emergency stop pin, active low
    input wire logic ext_estop_n,
    // Motor and output pins
    output logic motor_power_en,
    output logic brake_relay_out,
    output logic contactor_out,
    output logic out3_setting_err,
    output logic drop_prevent_en
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] servo_word;
        logic [15:0] spindle_word;
        logic [15:0] regen_word;
        logic [1:0] control;
        logic [1:0] estop_sync;
        brake_pkg::brake_state_t state;
        logic [15:0] count;
        logic motor_power;
        logic brake;
        logic contactor;
        logic drop_prevent;
        logic [31:0] rdata;
    } state_t;

    state_t cur_r;
    state_t cur_nxt;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] be);
        logic [15:0] res;
        res = old;
        if (be[0]) begin
            res[7:0] = wd[7:0];
        end
        if (be[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction : merge16

    function automatic logic [1:0] out3_field(input logic [15:0] w);
        return w[brake_pkg::OUT3_SEL_LSB +: 2];
    endfunction : out3_field

    // ------------------------------------------------------------
    // Decoded settings and stop state
    // ------------------------------------------------------------
    logic [1:0] sel;
    logic estop_enabled;
    logic estop_active;
    logic wr_en;
    logic rd_en;

    assign sel = cur_r.control[brake_pkg::CTRL_SPINDLE_BIT] ? out3_field(cur_r.spindle_word)
                                                         : out3_field(cur_r.servo_word);
    // Only code 4 enables the pin; any other value leaves it ignored
    assign estop_enabled = cur_r.regen_word[brake_pkg::ESTOP_EN_LSB +: 4]
                           == brake_pkg::ESTOP_ENABLED;
    assign estop_active = nc_estop || (estop_enabled && !cur_r.estop_sync[1]);
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        cur_nxt = cur_r;
        // The stop pin is asynchronous; only the second stage is read
        cur_nxt.estop_sync = {cur_r.estop_sync[0], ext_estop_n};

        // ------------------------------------------------------------
        // Register writes, taken in the access phase
        // ------------------------------------------------------------
        if (wr_en) begin
            if (paddr == brake_pkg::SERVO_FUNC5_ADDR) begin
                cur_nxt.servo_word = merge16(cur_r.servo_word, pwdata, pstrb);
            end else if (paddr == brake_pkg::SPINDLE_FUNC7_ADDR) begin
                cur_nxt.spindle_word = merge16(cur_r.spindle_word, pwdata, pstrb);
            end else if (paddr == brake_pkg::REGEN_TYPE_ADDR) begin
                cur_nxt.regen_word = merge16(cur_r.regen_word, pwdata, pstrb);
            end else if (paddr == brake_pkg::CONTROL_ADDR) begin
                if (pstrb[0]) begin
                    cur_nxt.control = pwdata[1:0];
                end
            end
        end

        // ------------------------------------------------------------
        // Read data
        // ------------------------------------------------------------
        // Captured in setup so it is stable in the access phase
        if (rd_en) begin
            cur_nxt.rdata = 32'h0000_0000;
            if (paddr == brake_pkg::SERVO_FUNC5_ADDR) begin
                cur_nxt.rdata = {16'h0000, cur_r.servo_word};
            end else if (paddr == brake_pkg::SPINDLE_FUNC7_ADDR) begin
                cur_nxt.rdata = {16'h0000, cur_r.spindle_word};
            end else if (paddr == brake_pkg::REGEN_TYPE_ADDR) begin
                cur_nxt.rdata = {16'h0000, cur_r.regen_word};
            end else if (paddr == brake_pkg::CONTROL_ADDR) begin
                cur_nxt.rdata = {30'h0000_0000, cur_r.control};
            end else if (paddr == brake_pkg::STATUS_ADDR) begin
                cur_nxt.rdata = {24'h00_0000, 1'b0, cur_r.state, estop_active,
                                 cur_r.drop_prevent, cur_r.contactor, cur_r.brake,
                                 cur_r.motor_power};
            end
        end

        // ------------------------------------------------------------
        // Drop prevention
        // ------------------------------------------------------------
        // Only for emergency stops, never for servo OFF
        cur_nxt.drop_prevent = estop_active;

        // ------------------------------------------------------------
        // Brake sequencer
        // ------------------------------------------------------------
        // Brake = 1 means engaged. Power comes up first; the brake lets go
        // only after torque has stood for the full release delay.
        case (cur_r.state)
            brake_pkg::ST_HELD: begin
                cur_nxt.brake = 1'b1;
                cur_nxt.motor_power = 1'b0;
                cur_nxt.count = 16'h0000;
                if (servo_on_cmd && !estop_active) begin
                    cur_nxt.motor_power = 1'b1;
                    cur_nxt.state = brake_pkg::ST_POWERING;
                end
            end
            brake_pkg::ST_POWERING: begin
                if (!servo_on_cmd || estop_active) begin
                    cur_nxt.motor_power = 1'b0;
                    cur_nxt.state = brake_pkg::ST_HELD;
                end else if (torque_on) begin
                    // Wait for torque to be present before letting go
                    if (cur_r.count >= 16'(RELEASE_DELAY - 1)) begin
                        cur_nxt.brake = 1'b0;
                        cur_nxt.state = brake_pkg::ST_RELEASED;
                    end else begin
                        cur_nxt.count = cur_r.count + 16'h0001;
                    end
                end else begin
                    cur_nxt.count = 16'h0000;
                end
            end
            brake_pkg::ST_RELEASED: begin
                // Power and brake change together; no drop prevention here
                if (!servo_on_cmd || estop_active || !torque_on) begin
                    cur_nxt.motor_power = 1'b0;
                    cur_nxt.brake = 1'b1;
                    cur_nxt.state = brake_pkg::ST_HELD;
                end
            end
            default: begin
                cur_nxt.state = brake_pkg::ST_HELD;
                cur_nxt.brake = 1'b1;
                cur_nxt.motor_power = 1'b0;
            end
        endcase

        // ------------------------------------------------------------
        // Output three
        // ------------------------------------------------------------
        // Contactor only with code 10; prohibited codes keep it off too
        if (sel == brake_pkg::OUT3_CONTACTOR) begin
            cur_nxt.contactor = cur_r.control[brake_pkg::CTRL_CONTACTOR_BIT]
                                && !estop_active;
        end else begin
            cur_nxt.contactor = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cur_r.servo_word <= brake_pkg::FUNC_WORD_RST;
            cur_r.spindle_word <= brake_pkg::FUNC_WORD_RST;
            cur_r.regen_word <= brake_pkg::FUNC_WORD_RST;
            cur_r.control <= brake_pkg::CONTROL_RST;
            cur_r.estop_sync <= 2'h3;
            cur_r.state <= brake_pkg::ST_HELD;
            cur_r.count <= 16'h0000;
            cur_r.motor_power <= 1'b0;
            cur_r.brake <= 1'b1;
            cur_r.contactor <= 1'b0;
            cur_r.drop_prevent <= 1'b0;
            cur_r.rdata <= 32'h0000_0000;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign prdata = cur_r.rdata;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign motor_power_en = cur_r.motor_power;
    assign brake_relay_out = cur_r.brake;
    assign contactor_out = cur_r.contactor;
    assign out3_setting_err = (sel != brake_pkg::OUT3_DISABLED)
                              && (sel != brake_pkg::OUT3_CONTACTOR);
    assign drop_prevent_en = cur_r.drop_prevent;

endmodule : brake_contactor_ctrl

// ### test/motor_relay_model.sv
// Far-side model: motor power stage producing torque after a lag
`timescale 1ns/1ps

module motor_relay_model (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Drive side
    input wire logic power_en,
    input wire logic slow,
    output logic torque_on
);
    logic [7:0] lag_r;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            lag_r <= 8'h00;
        end else begin
            lag_r <= {lag_r[6:0], power_en};
        end
    end

    // Torque dies with power at once but builds up only after a lag
    assign torque_on = power_en & (slow ? lag_r[7] : lag_r[0]);
endmodule : motor_relay_model

// ### test/brake_ctrl_assertions.sv
// Checker: port properties of the brake and contactor sequencer
`timescale 1ns/1ps

module brake_ctrl_checker #(
    parameter int RELEASE_DELAY = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Commands and status
    input wire logic servo_on_cmd,
    input wire logic nc_estop,
    input wire logic torque_on,
    input wire logic ext_estop_n,
    // Outputs
    input wire logic motor_power_en,
    input wire logic brake_relay_out,
    input wire logic contactor_out,
    input wire logic out3_setting_err,
    input wire logic drop_prevent_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // Margin of 4 covers the stop synchroniser and the power-up cycle
    int held_r;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            held_r <= 0;
        end else begin
            held_r <= (torque_on && servo_on_cmd && !nc_estop && ext_estop_n) ? held_r + 1 : 0;
        end
    end

    chk_brake_power: assert property (!brake_relay_out |-> motor_power_en)
        else $error("brake released without motor power");
    chk_torque_loss: assert property (!torque_on |=> brake_relay_out)
        else $error("brake released without torque");
    chk_release_time: assert property (held_r > RELEASE_DELAY + 4 |-> !brake_relay_out)
        else $error("brake not released in time");
    chk_off_together: assert property ($fell(motor_power_en) |-> brake_relay_out)
        else $error("power removed before brake engaged");
    chk_power_first: assert property ($fell(brake_relay_out) |-> $past(motor_power_en, 2))
        else $error("brake released before power on");
    chk_estop_hold: assert property (nc_estop |=> brake_relay_out && !motor_power_en)
        else $error("brake not held in stop");
    chk_no_drop_prev: assert property ((!nc_estop && ext_estop_n)[*4] |-> !drop_prevent_en)
        else $error("drop prevention without stop");
    chk_select_err: assert property (out3_setting_err && $past(out3_setting_err) |-> !contactor_out)
        else $error("contactor on with bad select");
    chk_restore_ctrl: assert property ($rose(servo_on_cmd) && !nc_estop && ext_estop_n |=> motor_power_en)
        else $error("motor power not restored");

    cov_release: cover property ($fell(brake_relay_out));
    cov_estop: cover property ($rose(nc_estop));
    cov_contactor: cover property ($rose(contactor_out));
endmodule : brake_ctrl_checker

bind brake_contactor_ctrl brake_ctrl_checker #(.RELEASE_DELAY(RELEASE_DELAY)) chk_i (
    .clk(clk), .arst_n(arst_n), .servo_on_cmd(servo_on_cmd), .nc_estop(nc_estop),
    .torque_on(torque_on), .ext_estop_n(ext_estop_n), .motor_power_en(motor_power_en),
    .brake_relay_out(brake_relay_out), .contactor_out(contactor_out),
    .out3_setting_err(out3_setting_err), .drop_prevent_en(drop_prevent_en)
);

// ### test/test_brake_contactor_output_control.sv
// Testbench: register access and brake/contactor sequencing
`timescale 1ns/1ps

module test_brake_contactor_output_control;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hf;
    logic servo_on_cmd = 1'b0;
    logic nc_estop = 1'b0;
    logic ext_estop_n = 1'b1;
    logic slow = 1'b1;
    logic [31:0] prdata;
    logic pready, pslverr, torque_on, motor_power_en, brake_relay_out, contactor_out;
    logic out3_setting_err, drop_prevent_en;
    int miscompares = 0;
    int n_checks = 0;

    always #5 clk = ~clk;

    brake_contactor_ctrl #(.RELEASE_DELAY(4)) uut (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .servo_on_cmd(servo_on_cmd), .nc_estop(nc_estop),
        .torque_on(torque_on), .ext_estop_n(ext_estop_n), .motor_power_en(motor_power_en),
        .brake_relay_out(brake_relay_out), .contactor_out(contactor_out),
        .out3_setting_err(out3_setting_err), .drop_prevent_en(drop_prevent_en)
    );

    motor_relay_model partner (
        .clk(clk), .arst_n(arst_n), .power_en(motor_power_en), .slow(slow), .torque_on(torque_on)
    );

    task results;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask : chk

    // One APB transfer; the trailing idle edge keeps psel from being set twice in one step
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            miscompares++;
            results();
        end
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr

    task rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk("prdata", e, q);
        chk("pslverr", 32'h0, 32'(pslverr));
    endtask : rd

    task await_brake(input logic v);
        int n;
        n = 0;
        while (brake_relay_out !== v && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk("brake wait", 32'(v), 32'(brake_relay_out));
        if (n >= 200) begin
            results();
        end
    endtask : await_brake

    initial begin
        repeat (6) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        chk("brake reset", 32'h1, 32'(brake_relay_out));
        rd(8'h14, 32'h0);
        wr(8'h0c, 32'h2);
        for (int i = 0; i < 4; i++) begin
            wr(8'h00, 32'(i) << 10);
            rd(8'h00, 32'(i) << 10);
            chk("select err", 32'(i[0]), 32'(out3_setting_err));
            chk("contactor", 32'(i == 2), 32'(contactor_out));
        end
        wr(8'h0c, 32'h3);
        wr(8'h04, 32'h800);
        repeat (2) @(posedge clk);
        chk("spindle contactor", 32'h1, 32'(contactor_out));
        wr(8'h04, 32'h400);
        chk("spindle err", 32'h1, 32'(out3_setting_err));
        servo_on_cmd <= 1'b1;
        repeat (2) @(posedge clk);
        chk("power on", 32'h1, 32'(motor_power_en));
        chk("held no torque", 32'h1, 32'(brake_relay_out));
        await_brake(1'b0);
        rd(8'h10, 32'h41);
        rd(8'h0c, 32'h3);
        servo_on_cmd <= 1'b0;
        repeat (2) @(posedge clk);
        chk("power off", 32'h0, 32'(motor_power_en));
        chk("brake on", 32'h1, 32'(brake_relay_out));
        chk("no drop prevent", 32'h0, 32'(drop_prevent_en));
        slow <= 1'b0;
        servo_on_cmd <= 1'b1;
        await_brake(1'b0);
        nc_estop <= 1'b1;
        repeat (2) @(posedge clk);
        chk("stop brake", 32'h1, 32'(brake_relay_out));
        chk("drop prevent", 32'h1, 32'(drop_prevent_en));
        nc_estop <= 1'b0;
        await_brake(1'b0);
        wr(8'h08, 32'h40);
        ext_estop_n <= 1'b0;
        await_brake(1'b1);
        ext_estop_n <= 1'b1;
        await_brake(1'b0);
        wr(8'h08, 32'h0);
        ext_estop_n <= 1'b0;
        repeat (8) @(posedge clk);
        chk("ext ignored", 32'h0, 32'(brake_relay_out));
        ext_estop_n <= 1'b1;
        results();
    end
endmodule : test_brake_contactor_output_control
